// [src/mdc_top.sv]
// maneuver duration counter: command decode, duration shift registers, overflow
// What this block does
// - address bits one to five pulse address triggers
// - bits six to seventeen pass strobe and data
// - bit eighteen loads polarity; address gates inhibited
// - parity flop toggles on each one bit
// - parity set after bit eighteen: parity-good pulse
// - address codes decoded from bits four, five
// - bit eighteen one positive, zero negative turn
// - three independent eleven-bit duration registers
// - pitch enable: decode or run flop, clamped
// - roll enable: decode or run flop, clamped
// - velocity run sets when roll run ends on turn overflow
// - load strobes only under clamp with enable
// - each shift in two phases via holding
// - one bit per strobe; bits 7-17 stay
// - one-per-second pulse shifts running turn registers
// - twenty-per-second pulse shifts after burn start
// - feedback stage nine xor eleven to one
// - feedback open when no run flop set
// - all-ones overflow clears run flops; a turn overflow clears both pitch and roll
// - combined overflow is or of both
// - twenty per second: twenty-five minus fifth
// - command alert resets bit counter and parity flops; address flops keep their value
`timescale 1ns/100ps
`default_nettype none

module mdc_top #(
	parameter int unsigned SLOW_DIV = mdc_pkg::SLOW_CYCLES,
	parameter int unsigned FAST_DIV = mdc_pkg::FAST_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [mdc_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic command_alert,
	input wire logic command_strobe,
	input wire logic command_data,
	input wire logic pitch_start_signal,
	input wire logic roll_start_signal,
	input wire logic burn_start_signal,
	input wire logic midcourse_clamp,
	output logic address_trigger,
	output logic register_shift_strobe,
	output logic register_serial_data,
	output logic polarity_load_strobe,
	output logic parity_good_pulse,
	output logic [mdc_pkg::NREG-1:0] register_enable,
	output logic pitch_polarity,
	output logic roll_polarity,
	output logic turn_overflow,
	output logic velocity_overflow,
	output logic any_register_overflow
);
	import mdc_pkg::*;

	function automatic logic all_ones(input logic [SR_W-1:0] v);
		all_ones = &v;
	endfunction
	function automatic logic [SR_W-1:0] shift_in(input logic [SR_W-1:0] v, input logic b);
		shift_in = {v[SR_W-2:0], b};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int unsigned NPIN = 7;
	logic [NPIN-1:0] pin_meta_reg;
	logic [NPIN-1:0] pin_sync_reg;
	logic [NPIN-1:0] pin_prev_reg;
	wire logic [NPIN-1:0] pin_raw = {midcourse_clamp, burn_start_signal, roll_start_signal,
		pitch_start_signal, command_data, command_strobe, command_alert};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			pin_prev_reg <= '0;
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end
	wire logic alert_s = pin_sync_reg[0];
	wire logic strobe_fall = pin_prev_reg[1] & ~pin_sync_reg[1];
	wire logic data_s = pin_sync_reg[2];
	wire logic pitch_go = pin_sync_reg[3] & ~pin_prev_reg[3];
	wire logic roll_go = pin_sync_reg[4] & ~pin_prev_reg[4];
	wire logic burn_go = pin_sync_reg[5] & ~pin_prev_reg[5];
	wire logic clamp_s = pin_sync_reg[6];
	wire logic clamp_on = pin_sync_reg[6] & ~pin_prev_reg[6];

	////////////////////////////////////////////////////////////////////////////
	// register bus
	logic tb_en_reg;
	logic pc_clr_reg;
	logic [PARCNT_W-1:0] parcnt_reg;
	wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic bus_wr = bus_req & wb_we_i;

	////////////////////////////////////////////////////////////////////////////
	// pulse rate dividers
	logic [DIV_W-1:0] slow_cnt_reg;
	logic [DIV_W-1:0] fast_cnt_reg;
	logic [2:0] gap_cnt_reg;
	logic slow_tick_reg;
	logic fast_tick_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			slow_cnt_reg <= '0;
			slow_tick_reg <= 1'b0;
		end else if (!tb_en_reg) begin
			slow_cnt_reg <= '0;
			slow_tick_reg <= 1'b0;
		end else begin
			slow_tick_reg <= (slow_cnt_reg == DIV_W'(SLOW_DIV - 1));
			slow_cnt_reg <= (slow_cnt_reg == DIV_W'(SLOW_DIV - 1)) ? '0 : slow_cnt_reg + 1'b1;
		end
	end

	// twenty-five per second train with every fifth pulse dropped
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fast_cnt_reg <= '0;
			gap_cnt_reg <= '0;
			fast_tick_reg <= 1'b0;
		end else if (!tb_en_reg) begin
			fast_cnt_reg <= '0;
			gap_cnt_reg <= '0;
			fast_tick_reg <= 1'b0;
		end else begin
			fast_tick_reg <= 1'b0;
			if (fast_cnt_reg == DIV_W'(FAST_DIV - 1)) begin
				fast_cnt_reg <= '0;
				gap_cnt_reg <= (gap_cnt_reg == GAP_LAST) ? '0 : gap_cnt_reg + 1'b1;
				fast_tick_reg <= (gap_cnt_reg != GAP_LAST);
			end else begin
				fast_cnt_reg <= fast_cnt_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input decoder
	logic [BITCNT_W-1:0] bit_cnt_reg;
	logic parity_reg;
	logic [1:0] addr_reg;
	logic par_check_reg;
	wire logic word_bit = strobe_fall & ~alert_s & (bit_cnt_reg < WORD_BITS);
	wire logic in_addr = bit_cnt_reg < ADDR_BITS;
	wire logic in_data = (bit_cnt_reg >= ADDR_BITS) & (bit_cnt_reg <= LAST_DATA_CNT);
	wire logic in_pol = bit_cnt_reg == POL_CNT;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_reg <= '0;
			parity_reg <= 1'b0;
			par_check_reg <= 1'b0;
		end else if (alert_s) begin
			bit_cnt_reg <= '0;
			parity_reg <= 1'b0;
			par_check_reg <= 1'b0;
		end else begin
			par_check_reg <= word_bit & in_pol;
			if (word_bit) begin
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
				parity_reg <= parity_reg ^ data_s;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= '0;
		end else if (word_bit && in_addr) begin
			addr_reg <= {addr_reg[0], data_s};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			address_trigger <= 1'b0;
			register_shift_strobe <= 1'b0;
			register_serial_data <= 1'b0;
			polarity_load_strobe <= 1'b0;
			parity_good_pulse <= 1'b0;
		end else begin
			address_trigger <= word_bit & in_addr;
			register_shift_strobe <= word_bit & in_data;
			if (word_bit && in_data) begin
				register_serial_data <= data_s;
			end
			polarity_load_strobe <= word_bit & in_pol;
			parity_good_pulse <= par_check_reg & parity_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// run and burn flip-flops
	logic run_p_reg;
	logic run_r_reg;
	logic run_v_reg;
	logic burn_reg;
	logic turn_ovf;
	logic vel_ovf;
	logic [SR_W-1:0] stage_reg [NREG];
	wire logic any_run = run_p_reg | run_r_reg | run_v_reg;
	wire logic addr_gate = in_data & ~alert_s;
	wire logic [NREG-1:0] dec_en = {addr_gate & (addr_reg == ADDR_VEL),
		addr_gate & (addr_reg == ADDR_ROLL), addr_gate & (addr_reg == ADDR_PITCH)};
	wire logic [NREG-1:0] en_now = dec_en | {run_v_reg, run_r_reg, run_p_reg};

	always_comb begin
		turn_ovf = (run_p_reg & all_ones(stage_reg[R_PITCH]))
			| (run_r_reg & all_ones(stage_reg[R_ROLL]));
		vel_ovf = run_v_reg & all_ones(stage_reg[R_VEL]);
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_p_reg <= 1'b0;
			run_r_reg <= 1'b0;
			run_v_reg <= 1'b0;
		end else if (clamp_s) begin
			run_p_reg <= 1'b0;
			run_r_reg <= 1'b0;
			run_v_reg <= 1'b0;
		end else begin
			run_p_reg <= pitch_go | (run_p_reg & ~turn_ovf);
			run_r_reg <= roll_go | (run_r_reg & ~turn_ovf);
			run_v_reg <= (run_r_reg & turn_ovf & ~roll_go) | (run_v_reg & ~vel_ovf);
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			burn_reg <= 1'b0;
		end else if (burn_go) begin
			burn_reg <= 1'b1;
		end else if (clamp_on) begin
			burn_reg <= 1'b0;
		end
	end
	// polarity flops: bit eighteen sets, start of the turn clears
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pitch_polarity <= 1'b0;
			roll_polarity <= 1'b0;
		end else begin
			if (word_bit && in_pol && data_s && addr_reg == ADDR_PITCH) begin
				pitch_polarity <= 1'b1;
			end else if (pitch_go && !clamp_s) begin
				pitch_polarity <= 1'b0;
			end
			if (word_bit && in_pol && data_s && addr_reg == ADDR_ROLL) begin
				roll_polarity <= 1'b1;
			end else if (roll_go && !clamp_s) begin
				roll_polarity <= 1'b0;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			register_enable <= '0;
			turn_overflow <= 1'b0;
			velocity_overflow <= 1'b0;
			any_register_overflow <= 1'b0;
		end else begin
			register_enable <= en_now;
			turn_overflow <= turn_ovf;
			velocity_overflow <= vel_ovf;
			any_register_overflow <= turn_ovf | vel_ovf;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// duration shift registers, two-phase shifting
	mdc_phase_t phase_reg;
	logic [NREG-1:0] pend_reg;
	logic [NREG-1:0] act_reg;
	logic [NREG-1:0] pend_data_reg;
	logic [NREG-1:0] act_data_reg;
	logic [SR_W-1:0] hold_reg [NREG];
	logic [NREG-1:0] req;
	logic load_ok;

	always_comb begin
		load_ok = word_bit & in_data & clamp_s & (|en_now);
		req[R_PITCH] = (load_ok & en_now[R_PITCH]) | (slow_tick_reg & run_p_reg);
		req[R_ROLL] = (load_ok & en_now[R_ROLL]) | (slow_tick_reg & run_r_reg);
		req[R_VEL] = (load_ok & en_now[R_VEL]) | (fast_tick_reg & burn_reg);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= PH_IDLE;
			pend_reg <= '0;
			act_reg <= '0;
			pend_data_reg <= '0;
			act_data_reg <= '0;
		end else begin
			pend_reg <= ((phase_reg == PH_IDLE) ? '0 : pend_reg) | req;
			pend_data_reg <= (pend_data_reg & ~req) | ({NREG{data_s}} & req);
			unique case (phase_reg)
				PH_IDLE: begin
					if (|pend_reg) begin
						act_reg <= pend_reg;
						act_data_reg <= pend_data_reg;
						phase_reg <= PH_ALPHA;
					end
				end
				PH_ALPHA: phase_reg <= PH_BETA;
				PH_BETA: phase_reg <= PH_IDLE;
				default: phase_reg <= PH_IDLE;
			endcase
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NREG; i++) begin
				hold_reg[i] <= '0;
				stage_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NREG; i++) begin
				if (phase_reg == PH_ALPHA && act_reg[i]) begin
					hold_reg[i] <= shift_in(stage_reg[i], any_run ?
						(stage_reg[i][FB_TAP_A] ^ stage_reg[i][FB_TAP_B]) : act_data_reg[i]);
				end
				if (phase_reg == PH_BETA && act_reg[i]) begin
					stage_reg[i] <= hold_reg[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register bus slave
	wire logic [31:0] status_word = {17'h0, clamp_s, burn_reg, run_v_reg, run_r_reg, run_p_reg,
		roll_polarity, pitch_polarity, parity_reg, addr_reg, bit_cnt_reg};
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				unique case (wb_adr_i)
					OFS_CTRL: wb_dat_o <= {30'h0, 1'b0, tb_en_reg};
					OFS_STATUS: wb_dat_o <= status_word;
					OFS_PITCH: wb_dat_o <= {21'h0, stage_reg[R_PITCH]};
					OFS_ROLL: wb_dat_o <= {21'h0, stage_reg[R_ROLL]};
					OFS_VEL: wb_dat_o <= {21'h0, stage_reg[R_VEL]};
					OFS_PARCNT: wb_dat_o <= {16'h0, parcnt_reg};
					default: wb_dat_o <= '0;
				endcase
			end
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tb_en_reg <= CTRL_TB_EN_RST;
			pc_clr_reg <= 1'b0;
		end else begin
			pc_clr_reg <= 1'b0;
			if (bus_wr && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
				tb_en_reg <= wb_dat_i[CTRL_TB_EN];
				pc_clr_reg <= wb_dat_i[CTRL_PC_CLR];
			end
		end
	end
	// count of parity-good events; a pulse beside a clear still counts
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			parcnt_reg <= '0;
		end else if (pc_clr_reg) begin
			parcnt_reg <= {{(PARCNT_W-1){1'b0}}, parity_good_pulse};
		end else if (parity_good_pulse) begin
			parcnt_reg <= parcnt_reg + 1'b1;
		end
	end
endmodule

`default_nettype wire

// [src/mdc_pkg.sv]
// constants shared by the maneuver duration counter
package mdc_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned SLOW_PERIOD_MS = 1000;
	localparam int unsigned FAST_PERIOD_MS = 40;
	localparam int unsigned SLOW_CYCLES = SLOW_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned FAST_CYCLES = FAST_PERIOD_MS * CYC_PER_MS;
	localparam int unsigned DIV_W = 28;

	localparam int unsigned SR_W = 11;
	localparam int unsigned FB_TAP_A = 8;
	localparam int unsigned FB_TAP_B = 10;
	localparam int unsigned NREG = 3;
	localparam int unsigned R_PITCH = 0;
	localparam int unsigned R_ROLL = 1;
	localparam int unsigned R_VEL = 2;

	localparam int unsigned BITCNT_W = 5;
	localparam logic [4:0] ADDR_BITS = 5'h05;
	localparam logic [4:0] LAST_DATA_CNT = 5'h10;
	localparam logic [4:0] POL_CNT = 5'h11;
	localparam logic [4:0] WORD_BITS = 5'h12;
	localparam logic [1:0] ADDR_PITCH = 2'h2;
	localparam logic [1:0] ADDR_ROLL = 2'h1;
	localparam logic [1:0] ADDR_VEL = 2'h3;

	localparam logic [2:0] GAP_LAST = 3'h4;

	localparam int unsigned WB_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PITCH = 8'h08;
	localparam logic [7:0] OFS_ROLL = 8'h0c;
	localparam logic [7:0] OFS_VEL = 8'h10;
	localparam logic [7:0] OFS_PARCNT = 8'h14;
	localparam int unsigned CTRL_TB_EN = 0;
	localparam int unsigned CTRL_PC_CLR = 1;
	localparam logic CTRL_TB_EN_RST = 1'h1;
	localparam int unsigned PARCNT_W = 16;

	typedef enum logic [2:0] {
		PH_IDLE = 3'h1,
		PH_ALPHA = 3'h2,
		PH_BETA = 3'h4
	} mdc_phase_t;
endpackage

// [bench/mdc_top_props.sv]
// checker: bus handshake, decoder pulses and overflow relations
`timescale 1ns/100ps
`default_nettype none
module mdc_top_props (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic midcourse_clamp,
	input wire logic address_trigger,
	input wire logic register_shift_strobe,
	input wire logic polarity_load_strobe,
	input wire logic parity_good_pulse,
	input wire logic [mdc_pkg::NREG-1:0] register_enable,
	input wire logic turn_overflow,
	input wire logic velocity_overflow,
	input wire logic any_register_overflow
);
	import mdc_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_turns_off;
		##[1:2] (register_enable[1:0] == 2'h0);
	endsequence
	sequence s_roll_end;
		$fell(register_enable[1]) && $past(turn_overflow) && !midcourse_clamp;
	endsequence
	////////////////////////////////////////////////////////////////
	a_bus_ack_one: assert property (s_taken |=> wb_ack_o)
		else $error("ack missing after request");
	a_bus_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_trig_pulse: assert property (address_trigger |=> !address_trigger)
		else $error("address trigger not a single pulse");
	a_shift_pulse: assert property (register_shift_strobe |=> !register_shift_strobe)
		else $error("shift strobe not a single pulse");
	a_parity_follows: assert property (parity_good_pulse |-> $past(polarity_load_strobe))
		else $error("parity good without polarity strobe");
	a_overflow_or: assert property (any_register_overflow == (turn_overflow || velocity_overflow))
		else $error("combined overflow wrong");
	a_turn_clears_run: assert property (turn_overflow |-> s_turns_off)
		else $error("turn run not cleared by overflow");
	a_vel_follows_roll: assert property (s_roll_end |-> ##[0:2] register_enable[2])
		else $error("velocity run not set at roll end");
endmodule
bind mdc_top mdc_top_props i_props (
	.clock(clock),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.midcourse_clamp(midcourse_clamp),
	.address_trigger(address_trigger),
	.register_shift_strobe(register_shift_strobe),
	.polarity_load_strobe(polarity_load_strobe),
	.parity_good_pulse(parity_good_pulse),
	.register_enable(register_enable),
	.turn_overflow(turn_overflow),
	.velocity_overflow(velocity_overflow),
	.any_register_overflow(any_register_overflow)
);
`default_nettype wire

// [bench/mdc_sender.sv]
// command sender model: alert, then eighteen strobed serial bits
`timescale 1ns/100ps
`default_nettype none
module mdc_sender (
	input wire logic clock,
	output logic command_alert,
	output logic command_strobe,
	output logic command_data
);
	initial begin
		command_alert = 1'b0;
		command_strobe = 1'b0;
		command_data = 1'b0;
	end
	task automatic send(input logic [4:0] a, input logic [10:0] v, input logic pol, input logic bad);
		logic [17:0] word;
		word = {a, ~(^{a, v, pol}) ^ bad, v, pol};
		@(posedge clock);
		command_alert <= 1'b1;
		repeat (4) @(posedge clock);
		command_alert <= 1'b0;
		for (int i = 17; i >= 0; i--) begin
			repeat (4) @(posedge clock);
			command_data <= word[i];
			command_strobe <= 1'b1;
			repeat (4) @(posedge clock);
			command_strobe <= 1'b0;
			repeat (4) @(posedge clock);
			command_data <= ~word[i];
		end
		repeat (8) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// [bench/mdc_top_bench.sv]
// bench: command loads, bus reads and a full maneuver run
`timescale 1ns/100ps
`default_nettype none
module mdc_top_bench;
	import mdc_pkg::*;
	logic clock, rst_n, cyc, stb, we, clamp, p_start, r_start, b_start;
	logic ack, trig, shs, pls, pgood, ppol, rpol, tov, vov, aov, alert, strobe, data, sdat;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [2:0] ren;
	int err_count = 0;
	int tests_run = 0;
	int n_trig = 0;
	int n_shift = 0;
	int n_pol = 0;
	int n_pg = 0;
	wire [4:0] watch = {vov, tov, ren};
	////////////////////////////////////////////////////////////////
	mdc_top #(.SLOW_DIV(20), .FAST_DIV(4)) i_dut (
		.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.command_alert(alert), .command_strobe(strobe), .command_data(data),
		.pitch_start_signal(p_start), .roll_start_signal(r_start),
		.burn_start_signal(b_start), .midcourse_clamp(clamp), .address_trigger(trig),
		.register_shift_strobe(shs), .register_serial_data(sdat), .polarity_load_strobe(pls),
		.parity_good_pulse(pgood), .register_enable(ren), .pitch_polarity(ppol),
		.roll_polarity(rpol), .turn_overflow(tov), .velocity_overflow(vov),
		.any_register_overflow(aov)
	);
	mdc_sender i_snd (.clock(clock), .command_alert(alert), .command_strobe(strobe),
		.command_data(data));
	////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		n_trig <= n_trig + (trig === 1'b1);
		n_shift <= n_shift + (shs === 1'b1);
		n_pol <= n_pol + (pls === 1'b1);
		n_pg <= n_pg + (pgood === 1'b1);
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d of %0d compares", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic wait_hi(input int idx);
		int n;
		n = 0;
		while (watch[idx] !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		if (n >= 400) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic cmd(input logic [4:0] a, input logic [7:0] ofs, input logic [10:0] v,
		input logic pol, input logic bad, input logic [10:0] exp);
		int t, s, p, g;
		t = n_trig;
		s = n_shift;
		p = n_pol;
		g = n_pg;
		i_snd.send(a, v, pol, bad);
		check(n_trig - t, 5);
		check(n_shift - s, 12);
		check(n_pol - p, 1);
		check(n_pg - g, {31'h0, ~bad});
		check(sdat, v[0]);
		bus(1'b0, ofs, 32'h0);
		check(q, {21'h0, exp});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		clamp = 1'b1;
		p_start = 1'b0;
		r_start = 1'b0;
		b_start = 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		bus(1'b0, OFS_CTRL, 32'h0);
		check(q, 32'h1);
		bus(1'b1, 8'h18, 32'hffffffff);
		bus(1'b0, 8'h18, 32'h0);
		check(q, 32'h0);
		cmd(5'h0e, OFS_PITCH, 11'h4ff, 1'b1, 1'b0, 11'h4ff);
		check(ppol, 1'b1);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q & 32'h31f, 32'h112);
		cmd(5'h01, OFS_ROLL, 11'h4ff, 1'b0, 1'b0, 11'h4ff);
		check(rpol, 1'b0);
		cmd(5'h0b, OFS_VEL, 11'h4ff, 1'b0, 1'b0, 11'h4ff);
		cmd(5'h0e, OFS_PITCH, 11'h4ff, 1'b1, 1'b1, 11'h4ff);
		bus(1'b0, OFS_PARCNT, 32'h0);
		check(q, 32'h3);
		bus(1'b1, OFS_CTRL, 32'h3);
		bus(1'b0, OFS_PARCNT, 32'h0);
		check(q, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b0, OFS_CTRL, 32'h0);
		check(q, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b0, OFS_CTRL, 32'h0);
		check(q, 32'h1);
		clamp <= 1'b0;
		repeat (8) @(posedge clock);
		p_start <= 1'b1;
		wait_hi(0);
		p_start <= 1'b0;
		check(ppol, 1'b0);
		wait_hi(3);
		check(aov, 1'b1);
		repeat (3) @(posedge clock);
		check(ren, 3'h0);
		bus(1'b0, OFS_PITCH, 32'h0);
		check(q, 32'h7ff);
		r_start <= 1'b1;
		wait_hi(1);
		r_start <= 1'b0;
		wait_hi(3);
		wait_hi(2);
		b_start <= 1'b1;
		wait_hi(4);
		check(aov, 1'b1);
		b_start <= 1'b0;
		cmd(5'h0e, OFS_PITCH, 11'h000, 1'b1, 1'b0, 11'h7ff);
		clamp <= 1'b1;
		repeat (8) @(posedge clock);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q & 32'h7c00, 32'h4000);
		summarize();
	end
endmodule
`default_nettype wire
